// *** rtl/rtc_strobe_gate.sv ***
`timescale 1ns/1ps

package rtc_port_pkg;
    // Bus widths of the nibble-wide host port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 4;
    localparam int REG_DEPTH = 16;
    // Control and status nibble
    localparam logic [3:0] CTRL_ADDR = 4'hE;
    localparam int PERIODIC_BIT = 0;
    localparam int ALARM_BIT = 1;
    localparam int HALT_BIT = 2;
    localparam int TICK_EN_BIT = 3;
    // Reset values of the output flip-flops
    localparam logic PIN_DRIVE_LEVEL = 1'b0;
    localparam logic OE_RELEASED = 1'b0;
    localparam logic STROBE_IDLE = 1'b0;
endpackage

// Qualifies one strobe with chip-select and marks its start and end
module rtc_strobe_gate
    import rtc_port_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Bus pins, active low
    input wire logic cs_n,
    input wire logic strobe_n,
    // Access phase
    output logic active,
    output logic start,
    output logic finish
);
    logic both_low; // Access condition this cycle

    // Access needs both pins low, whichever fell last
    assign both_low = !cs_n && !strobe_n;

    // Registered access phase, cleared at reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            active <= STROBE_IDLE;
        end else begin
            active <= both_low;
        end
    end

    // Edges of the access phase; cs held low leaves the strobe alone to decide
    assign start = both_low && !active;
    assign finish = !both_low && active;
endmodule

// *** rtl/rtc_parallel_bus_port.sv ***
`timescale 1ns/1ps

// Operation
// - Works with chip-select tied low permanently
// - Chip-select may precede or follow address
// - Registers undefined at power-on until written
// - Interrupt level undefined until registers written
// - Halt flag set keeps tick output released
// - Interrupt and tick outputs are open-drain
// - Interrupt is OR of alarm and periodic
module rtc_parallel_bus_port
    import rtc_port_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Host bus controls, active low
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [AW-1:0] addr,
    // Two-way data bus
    input wire logic [DW-1:0] data_in,
    output logic [DW-1:0] data_out,
    output logic data_oe,
    // Events from the timekeeping core
    input wire logic alarm_event,
    input wire logic periodic_event,
    input wire logic osc_start_event,
    input wire logic tick_level,
    // Open-drain interrupt pin
    output logic interrupt_out_n,
    output logic interrupt_out_n_oe,
    // Open-drain timing pin
    output logic tick_pulse_out,
    output logic tick_pulse_out_oe
);
    // Control bits need four data bits and the map sixteen addresses
    if (AW != ADDR_W || DW < DATA_W) begin : g_bad_width
        $error("rtc_parallel_bus_port: unsupported bus width");
    end

    logic rd_active; // Read phase
    logic wr_active; // Write phase
    logic wr_start; // Write phase begins
    logic wr_finish; // Write phase ends, commit point
    logic [AW-1:0] wr_addr; // Address held during write
    logic [DW-1:0] wr_data; // Data held during write
    logic [DW-1:0] mem [REG_DEPTH]; // Register array, never reset
    logic alarm_hit_flag; // Sticky alarm hit
    logic periodic_hit_flag; // Sticky periodic hit
    logic osc_halt_flag; // Sticky oscillator-start flag
    logic tick_enable; // Software gate for the timing pin
    logic ctrl_write; // Commit to control nibble
    logic [DW-1:0] next_rdata; // Value of the addressed register

    // Read strobe qualifier
    rtc_strobe_gate u_rd_gate (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .cs_n(cs_n),
        .strobe_n(rd_n),
        .active(rd_active),
        .start(),
        .finish()
    );

    // Write strobe qualifier
    rtc_strobe_gate u_wr_gate (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .cs_n(cs_n),
        .strobe_n(wr_n),
        .active(wr_active),
        .start(wr_start),
        .finish(wr_finish)
    );

    // Hold address and data while the write phase is open; the last
    // sample before the rising edge is what gets committed
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_addr <= '0;
            wr_data <= '0;
        end else if (wr_start || wr_active) begin
            wr_addr <= addr;
            wr_data <= data_in;
        end
    end

    assign ctrl_write = wr_finish && (wr_addr == CTRL_ADDR);

    // Plain storage nibbles; no reset, so contents are undefined until
    // software writes them, and reads before that return garbage
    always_ff @(posedge sys_clk) begin
        if (wr_finish && !ctrl_write) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Sticky event flags; no reset, set wins over a clearing write
    always_ff @(posedge sys_clk) begin
        if (ctrl_write) begin
            alarm_hit_flag <= alarm_event || wr_data[ALARM_BIT];
            periodic_hit_flag <= periodic_event || wr_data[PERIODIC_BIT];
        end else begin
            alarm_hit_flag <= alarm_event || alarm_hit_flag;
            periodic_hit_flag <= periodic_event || periodic_hit_flag;
        end
    end

    // Halt flag and tick enable, also undefined until written
    always_ff @(posedge sys_clk) begin
        if (ctrl_write) begin
            osc_halt_flag <= osc_start_event || wr_data[HALT_BIT];
            tick_enable <= wr_data[TICK_EN_BIT];
        end else if (osc_start_event) begin
            osc_halt_flag <= 1'b1;
        end
    end

    // Read mux, follows the address live so select/address order is free
    always_comb begin
        next_rdata = '0;
        if (addr == CTRL_ADDR) begin
            next_rdata[ALARM_BIT] = alarm_hit_flag;
            next_rdata[PERIODIC_BIT] = periodic_hit_flag;
            next_rdata[HALT_BIT] = osc_halt_flag;
            next_rdata[TICK_EN_BIT] = tick_enable;
        end else begin
            next_rdata = mem[addr];
        end
    end

    // Data bus driver: registered, enabled in the cycle after both read pins are low
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            data_out <= '0;
            data_oe <= OE_RELEASED;
        end else begin
            data_out <= next_rdata;
            data_oe <= !cs_n && !rd_n;
        end
    end

    // Interrupt pin; level follows flags, which may be garbage at power-on
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            interrupt_out_n <= PIN_DRIVE_LEVEL;
            interrupt_out_n_oe <= OE_RELEASED;
        end else begin
            interrupt_out_n <= PIN_DRIVE_LEVEL;
            interrupt_out_n_oe <= alarm_hit_flag || periodic_hit_flag;
        end
    end

    // Timing pin; held off while the halt flag is set, until a control write clears it
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tick_pulse_out <= PIN_DRIVE_LEVEL;
            tick_pulse_out_oe <= OE_RELEASED;
        end else begin
            tick_pulse_out <= PIN_DRIVE_LEVEL;
            tick_pulse_out_oe <= tick_level && tick_enable && !osc_halt_flag;
        end
    end

    // Flags are unknown until the first control write; the OR check waits
    // for it so that power-on garbage in the flags cannot trip it
    logic ctrl_written; // Control nibble written since reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_written <= 1'b0;
        end else if (ctrl_write) begin
            ctrl_written <= 1'b1;
        end
    end

    // Checks
    a_read_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
        data_oe |-> $past(!cs_n && !rd_n))
        else $error("data bus driven without select and read low");
    a_cs_tied_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!cs_n && $fell(rd_n)) ##0 !cs_n [*2] |-> data_oe)
        else $error("read with select held low not served");
    a_read_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!cs_n && !rd_n) |=> data_out == $past(next_rdata))
        else $error("read data does not follow address");
    a_write_commit: assert property (@(posedge sys_clk) disable iff (!resetn)
        (wr_finish && !ctrl_write) |=> mem[$past(wr_addr)] == $past(wr_data))
        else $error("write not committed at strobe end");
    a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
        alarm_event |=> alarm_hit_flag)
        else $error("alarm event lost");
    a_irq_or: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_written |=> interrupt_out_n_oe == $past(alarm_hit_flag || periodic_hit_flag))
        else $error("interrupt is not OR of sources");
    a_write_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_active |-> $past(!cs_n && !wr_n))
        else $error("write phase open without select and strobe low");
    a_halt_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
        osc_start_event |=> osc_halt_flag)
        else $error("oscillator start event lost");
    a_irq_release: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!alarm_hit_flag && !periodic_hit_flag) [*2] |-> !interrupt_out_n_oe)
        else $error("interrupt driven with no source");
    a_tick_halt: assert property (@(posedge sys_clk) disable iff (!resetn)
        osc_halt_flag |=> !tick_pulse_out_oe)
        else $error("timing pin driven while halt flag set");
    a_open_drain: assert property (@(posedge sys_clk) disable iff (!resetn)
        interrupt_out_n_oe |-> interrupt_out_n == 1'b0 && $past(resetn))
        else $error("open-drain pin not pulling low");

    c_read: cover property (@(posedge sys_clk) disable iff (!resetn)
        !cs_n && $fell(rd_n) ##1 data_oe);
    c_write: cover property (@(posedge sys_clk) disable iff (!resetn)
        wr_start ##[1:8] wr_finish);
    c_irq: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(interrupt_out_n_oe));
    c_tick: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(tick_pulse_out_oe));
    c_tick_held: cover property (@(posedge sys_clk) disable iff (!resetn)
        osc_halt_flag && tick_level && tick_enable);
endmodule

// *** testbench/host_bus_model.sv ***
`timescale 1ns/1ps

// Host CPU on the nibble bus; select stays low between accesses
module host_bus_model (
    // Clock
    input wire logic sys_clk,
    // Pins driven by the host
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] addr,
    output logic [3:0] host_data,
    output logic host_oe,
    // Data pins as seen on the wire
    input wire logic [3:0] bus_data
);
    // Idle bus before reset ends
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        host_data = 4'h0;
        host_oe = 1'b0;
    end

    // Strobe goes high-low-high; late_cs lowers select after strobe and data
    task automatic write_nib(input logic [3:0] a, input logic [3:0] d, input bit late_cs);
        @(posedge sys_clk);
        addr <= a;
        host_data <= d;
        host_oe <= 1'b1;
        wr_n <= 1'b0;
        cs_n <= late_cs;
        repeat (2) @(posedge sys_clk);
        cs_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        // Late case ends the access by select, before the strobe
        if (late_cs) cs_n <= 1'b1;
        else wr_n <= 1'b1;
        @(posedge sys_clk);
        wr_n <= 1'b1;
        cs_n <= 1'b0;
        host_oe <= 1'b0;
        // Released bus shows the inverse, never the stale value
        host_data <= ~d;
        repeat (2) @(posedge sys_clk);
    endtask

    // One read strobe; data taken while the strobe is still low
    task automatic read_nib(input logic [3:0] a, output logic [3:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        d = bus_data;
        rd_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

// *** testbench/tb_rtc_parallel_bus_port.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("Error %0t: got %h expected %h", $time, a, b); end end

module tb_rtc_parallel_bus_port;
    import rtc_port_pkg::*;
    // Clock, reset and core-side stimulus
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic alarm_event = 1'b0;
    logic periodic_event = 1'b0;
    logic osc_start_event = 1'b0;
    logic tick_level = 1'b0;
    // Bus wires
    logic cs_n, rd_n, wr_n, host_oe, data_oe;
    logic [3:0] addr, host_data, data_out, data_in, rd;
    logic interrupt_out_n, interrupt_out_n_oe, tick_pulse_out, tick_pulse_out_oe;
    int num_errors = 0;
    int n_compared = 0;

    // Wire level of the shared data pins
    assign data_in = data_oe ? data_out : host_data;
    always #12.5 sys_clk = ~sys_clk;

    // Host and device must never drive the data pins at once
    always @(negedge sys_clk) begin
        if (host_oe) `CHK(data_oe, 1'b0)
    end

    host_bus_model i_host_bus_model (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .host_data(host_data), .host_oe(host_oe),
        .bus_data(data_in));
    rtc_parallel_bus_port i_rtc_parallel_bus_port (.sys_clk(sys_clk), .resetn(resetn),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .alarm_event(alarm_event),
        .periodic_event(periodic_event), .osc_start_event(osc_start_event),
        .tick_level(tick_level), .interrupt_out_n(interrupt_out_n),
        .interrupt_out_n_oe(interrupt_out_n_oe), .tick_pulse_out(tick_pulse_out),
        .tick_pulse_out_oe(tick_pulse_out_oe));

    // Verdict and end of run
    task automatic stop_test;
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One-cycle event pulses from the core, then time for flag and pin
    task automatic pulse(input logic [2:0] ev);
        @(posedge sys_clk);
        {osc_start_event, periodic_event, alarm_event} <= ev;
        @(posedge sys_clk);
        {osc_start_event, periodic_event, alarm_event} <= 3'h0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Clearing control first removes the undefined interrupt level
    task automatic t_init;
        i_host_bus_model.write_nib(CTRL_ADDR, 4'h0, 1'b0);
        `CHK(interrupt_out_n_oe, 1'b0)
        `CHK(tick_pulse_out_oe, 1'b0)
    endtask

    // Plain nibbles 0 to 13 stored and read back with select held low
    task automatic t_store;
        for (int a = 0; a < 14; a++) i_host_bus_model.write_nib(4'(a), 4'(a ^ 5), 1'b0);
        for (int a = 0; a < 14; a++) begin
            i_host_bus_model.read_nib(4'(a), rd);
            `CHK(rd, 4'(a ^ 5))
        end
        // Select lowered after address and strobe, raised before the strobe
        i_host_bus_model.write_nib(4'h2, 4'hC, 1'b1);
        i_host_bus_model.read_nib(4'h2, rd);
        `CHK(rd, 4'hC)
    endtask

    // Interrupt pin is the OR of both flags, open-drain low
    task automatic t_irq;
        pulse(3'h1);
        `CHK(interrupt_out_n_oe, 1'b1)
        `CHK(interrupt_out_n, 1'b0)
        i_host_bus_model.read_nib(CTRL_ADDR, rd);
        `CHK(rd, 4'h2)
        pulse(3'h2);
        i_host_bus_model.write_nib(CTRL_ADDR, 4'h1, 1'b0);
        `CHK(interrupt_out_n_oe, 1'b1)
        i_host_bus_model.write_nib(CTRL_ADDR, 4'h0, 1'b0);
        `CHK(interrupt_out_n_oe, 1'b0)
    endtask

    // Halt flag keeps the timing pin released until cleared
    task automatic t_tick;
        tick_level <= 1'b1;
        i_host_bus_model.write_nib(CTRL_ADDR, 4'h8, 1'b0);
        `CHK(tick_pulse_out_oe, 1'b1)
        `CHK(tick_pulse_out, 1'b0)
        pulse(3'h4);
        `CHK(tick_pulse_out_oe, 1'b0)
        i_host_bus_model.read_nib(CTRL_ADDR, rd);
        `CHK(rd, 4'hC)
        i_host_bus_model.write_nib(CTRL_ADDR, 4'h8, 1'b0);
        `CHK(tick_pulse_out_oe, 1'b1)
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_init();
        t_store();
        t_irq();
        t_tick();
        stop_test();
    end
endmodule
